// *** core/smbus_eeprom_config_loader.sv ***
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module smbus_eeprom_config_loader
    import eeprom_loader_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_HOT_RST,
    input wire logic I_MASTER_BUS_SLOW_STRAP,
    input wire logic [2:0] I_SWITCH_OPERATING_STRAP,
    input wire logic [3:0] I_MASTER_BUS_ADDRESS_PINS,
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SCL,
    output logic O_SCL_OE,
    output logic O_SDA,
    output logic O_SDA_OE,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic O_CFG_WR,
    output logic [15:0] O_CFG_ADDR,
    output logic [31:0] O_CFG_DATA,
    input wire logic I_CFG_MISS,
    output logic O_LOAD_BUSY,
    output logic O_RESET_HALT
);

    // ****************************************
    // types and state
    // ****************************************

    typedef enum logic [3:0] {
        S_BOOT,
        S_IDLE,
        S_START,
        S_DEVW,
        S_AHI,
        S_ALO,
        S_RSTART,
        S_DEVR,
        S_READ,
        S_TAIL,
        S_STOP,
        S_FIN
    } st_t;

    typedef enum logic [2:0] {
        P_ALO,
        P_AHI,
        P_CNT0,
        P_CNT1,
        P_DATA
    } pst_t;

    typedef struct packed {
        logic [29:0] syn;
        logic [9:0] filt;
        logic [2:0] boot;
        logic fund;
        st_t st;
        pst_t ps;
        logic pend;
        logic go;
        cmd_t cmd;
        logic [7:0] wbyte;
        logic ack;
        logic [3:0] dev;
        logic [15:0] ee_addr;
        logic [7:0] lo;
        logic [13:0] waddr;
        logic [15:0] count;
        logic [31:0] data;
        logic [1:0] bidx;
        logic [7:0] sum;
        logic [4:0] lost_n;
        logic [15:0] presc;
        logic sum_ign;
        logic [5:0] flags;
        logic busy;
        logic halt;
        logic wr;
        logic [15:0] wr_addr;
        logic [31:0] wr_data;
        logic waitreq;
        logic [31:0] rdata;
        logic pin_lo;
    } top_t;

    top_t r;
    top_t n;

    logic [9:0] diff;
    logic req;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] wv;
    logic [7:0] b;
    logic [7:0] nsum;
    logic fin_ok;
    logic img;

    cmd_t c_cmd;
    logic [7:0] c_byte;
    logic c_ack;

    logic e_done;
    logic [7:0] e_rdata;
    logic e_nack;
    logic e_lost;
    logic e_misc;
    logic e_scl_oe;
    logic e_sda_oe;

    // byte lanes not enabled keep their old contents
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] be
    );
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (nw & m) | (old & ~m);
    endfunction

    // ****************************************
    // bit engine
    // ****************************************

    serial_bus_byte_engine u_serial_bus_byte_engine (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_go(r.go),
        .i_cmd(r.cmd),
        .i_wdata(r.wbyte),
        .i_ack(r.ack),
        .i_quarter(r.presc),
        .i_scl(r.filt[9]),
        .i_sda(r.filt[8]),
        .o_done(e_done),
        .o_rdata(e_rdata),
        .o_nack(e_nack),
        .o_lost(e_lost),
        .o_misc(e_misc),
        .o_scl_oe(e_scl_oe),
        .o_sda_oe(e_sda_oe)
    );

    // ****************************************
    // command for the current bus step
    // ****************************************

    always_comb begin
        c_cmd = CMD_WRITE;
        c_byte = 8'h00;
        c_ack = 1'b1;
        case (r.st)
            S_START: c_cmd = CMD_START;
            S_RSTART: c_cmd = CMD_START;
            S_DEVW: c_byte = {DEV_TOP, r.dev, 1'b0};
            S_DEVR: c_byte = {DEV_TOP, r.dev, 1'b1};
            S_AHI: c_byte = r.ee_addr[15:8];
            S_ALO: c_byte = r.ee_addr[7:0];
            S_READ: c_cmd = CMD_READ;
            S_TAIL: begin
                // extra byte read with NACK so the EEPROM lets go of data
                c_cmd = CMD_READ;
                c_ack = 1'b0;
            end
            S_STOP: c_cmd = CMD_STOP;
            default: c_cmd = CMD_WRITE;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************

    always_comb begin
        n = r;
        n.go = 1'b0;
        n.wr = 1'b0;
        n.waitreq = 1'b1;
        b = e_rdata;
        nsum = r.sum + e_rdata;
        fin_ok = 1'b0;
        img = 1'b0;
        wv = 32'h0000_0000;
        n.syn = {r.syn[19:0], I_SCL, I_SDA, I_MASTER_BUS_SLOW_STRAP,
                 I_SWITCH_OPERATING_STRAP, I_MASTER_BUS_ADDRESS_PINS};
        diff = r.syn[19:10] ^ r.syn[29:20];
        n.filt = (r.syn[29:20] & ~diff) | (r.filt & diff);
        req = I_AVS_READ | I_AVS_WRITE;
        ctrl_word = {15'h0000, r.sum_ign, r.presc};
        stat_word = {23'h00_0000, r.busy, 2'h0, r.flags};

        // register bus: one wait cycle, then the access completes
        if (req && r.waitreq) begin
            n.waitreq = 1'b0;
            case (I_AVS_ADDRESS)
                OFS_CTRL: n.rdata = ctrl_word;
                OFS_STAT: n.rdata = stat_word;
                OFS_SWITCH: n.rdata = {31'h0000_0000, r.halt};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
        if (req && !r.waitreq && I_AVS_WRITE) begin
            case (I_AVS_ADDRESS)
                OFS_CTRL: begin
                    wv = merge(ctrl_word, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                    n.presc = wv[15:0];
                    n.sum_ign = wv[CTRL_SUM_IGN];
                end
                OFS_STAT: begin
                    if (I_AVS_BYTEENABLE[0]) begin
                        n.flags = r.flags & ~I_AVS_WRITEDATA[5:0];
                    end
                end
                OFS_SWITCH: begin
                    wv = merge({31'h0000_0000, r.halt}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                    n.halt = wv[HALT_BIT];
                end
                default: n.halt = r.halt;
            endcase
        end

        // hardware sets below override a same-cycle software clear
        if (r.wr && I_CFG_MISS) begin
            n.flags[FLAG_UNMAP] = 1'b1;
        end

        case (r.st)
            S_BOOT: begin
                if (r.boot != BOOT_CYCLES) begin
                    n.boot = r.boot + 3'h1;
                end else begin
                    n.boot = 3'h0;
                    n.st = S_IDLE;
                    if (r.fund) begin
                        n.fund = 1'b0;
                        n.presc = r.filt[7] ? PRESC_SLOW : PRESC_FAST;
                    end
                    if (LOAD_MODES[r.filt[6:4]]) begin
                        n.st = S_START;
                        n.busy = 1'b1;
                        n.flags = 6'h00;
                        n.ee_addr = 16'h0000;
                        n.sum = 8'h00;
                        n.ps = P_ALO;
                        n.lost_n = 5'h00;
                        n.dev = r.filt[3:0];
                    end
                end
            end

            S_IDLE: begin
                if (I_HOT_RST) begin
                    n.st = S_BOOT;
                end
            end

            S_FIN: begin
                n.busy = 1'b0;
                n.flags[FLAG_DONE] = 1'b1;
                n.st = S_IDLE;
            end

            default: begin
                if (!r.pend) begin
                    n.go = 1'b1;
                    n.pend = 1'b1;
                    n.cmd = c_cmd;
                    n.wbyte = c_byte;
                    n.ack = c_ack;
                end else if (e_done) begin
                    n.pend = 1'b0;
                    if (e_lost) begin
                        n.lost_n = r.lost_n + 5'h01;
                        if (n.lost_n == LOST_LIMIT) begin
                            n.flags[FLAG_LOST] = 1'b1;
                            n.halt = 1'b1;
                            n.st = S_FIN;
                        end else begin
                            // retry the transaction at the current EEPROM address
                            n.st = S_START;
                        end
                    end else if (e_misc) begin
                        n.flags[FLAG_MISC] = 1'b1;
                        n.halt = 1'b1;
                        n.st = S_FIN;
                    end else if (e_nack) begin
                        n.lost_n = 5'h00;
                        n.flags[FLAG_NACK] = 1'b1;
                        n.halt = 1'b1;
                        n.st = S_STOP;
                    end else begin
                        n.lost_n = 5'h00;
                        case (r.st)
                            S_START: n.st = S_DEVW;
                            S_DEVW: n.st = S_AHI;
                            S_AHI: n.st = S_ALO;
                            S_ALO: n.st = S_RSTART;
                            S_RSTART: n.st = S_DEVR;
                            S_DEVR: n.st = S_READ;
                            S_TAIL: n.st = S_STOP;
                            S_STOP: n.st = S_FIN;
                            default: begin
                                n.sum = nsum;
                                n.ee_addr = r.ee_addr + 16'h0001;
                                case (r.ps)
                                    P_ALO: begin
                                        n.lo = b;
                                        n.ps = P_AHI;
                                    end
                                    P_AHI: begin
                                        n.waddr = {b[5:0], r.lo};
                                        n.bidx = 2'h0;
                                        case (b[7:6])
                                            TYPE_SINGLE: begin
                                                n.count = 16'h0001;
                                                n.ps = P_DATA;
                                            end
                                            TYPE_SEQ: n.ps = P_CNT0;
                                            TYPE_DONE: fin_ok = 1'b1;
                                            default: img = 1'b1;
                                        endcase
                                    end
                                    P_CNT0: begin
                                        n.count = {8'h00, b};
                                        n.ps = P_CNT1;
                                    end
                                    P_CNT1: begin
                                        n.count = {b, r.count[7:0]};
                                        n.ps = ({b, r.count[7:0]} == 16'h0000) ? P_ALO : P_DATA;
                                    end
                                    P_DATA: begin
                                        n.data = {b, r.data[31:8]};
                                        n.bidx = r.bidx + 2'h1;
                                        if (r.bidx == 2'h3) begin
                                            n.wr = 1'b1;
                                            n.wr_addr = {r.waddr, 2'h0};
                                            n.wr_data = {b, r.data[31:8]};
                                            n.waddr = r.waddr + 14'h0001;
                                            n.count = r.count - 16'h0001;
                                            if (r.count == 16'h0001) begin
                                                n.ps = P_ALO;
                                            end
                                        end
                                    end
                                    default: n.ps = P_ALO;
                                endcase
                                if (fin_ok && nsum != SUM_GOOD && !r.sum_ign) begin
                                    img = 1'b1;
                                end
                                if (!fin_ok && r.ee_addr == LAST_ADDR) begin
                                    img = 1'b1;
                                end
                                if (img) begin
                                    n.flags[FLAG_IMG] = 1'b1;
                                    n.halt = 1'b1;
                                    n.st = S_TAIL;
                                end else if (fin_ok) begin
                                    n.st = S_TAIL;
                                end
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            r <= '0;
            {r.syn, r.filt} <= {4{FILT_RESET}};
            r.fund <= 1'b1;
            r.presc <= PRESC_SLOW;
            r.waitreq <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    // the lines are open drain: driven only low, released otherwise
    assign O_SCL = r.pin_lo;
    assign O_SDA = r.pin_lo;
    assign O_SCL_OE = e_scl_oe;
    assign O_SDA_OE = e_sda_oe;

    assign O_AVS_READDATA = r.rdata;
    assign O_AVS_WAITREQUEST = r.waitreq;

    assign O_CFG_WR = r.wr;
    assign O_CFG_ADDR = r.wr_addr;
    assign O_CFG_DATA = r.wr_data;

    assign O_LOAD_BUSY = r.busy;
    assign O_RESET_HALT = r.halt;

endmodule

// *** common/eeprom_loader_pkg.sv ***
// Behaviour
// - slow strap at fundamental reset picks 100 KHz or 400 KHz prescaler.
// - load runs after fundamental or hot reset only in modes with EEPROM load.
// - EEPROM bus address is 1,0,1 then the four address pins.
// - block address is a word address; byte address appends two zero bits.
// - read bytes from address zero until done block ends or address wraps.
// - every register write is a full 32-bit word.
// - single block is six bytes: address, type 0, one data word.
// - sequential block: address, type 1, count, then count words to rising addresses.
// - done block holds checksum and type 3; its end completes the load.
// - write to an undefined register is dropped and the unmapped flag set.
// - 8-bit sum from zero over every byte read except the NACKed tail byte must end at 0xFF.
// - ignore-checksum control bit makes a sum mismatch harmless.
// - any error except an unmapped write aborts the load, sets reset halt and records status.
// - load-done flag is set on normal end and on abort.
// - sum mismatch, address wrap or type 2 set image error and abort.
// - unexpected NACK sets the no-acknowledge flag and aborts.
// - sixteenth consecutive lost arbitration sets its flag and aborts.
// - misplaced START or STOP sets the misc bus flag and aborts.
// - split buses work independently; slave side needs no arbitration.
// - slave port reads and writes all registers, including abort status.
// - no expander traffic on the master bus before the load finishes.
package eeprom_loader_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned SLOW_HZ = 100000;
    localparam int unsigned FAST_HZ = 400000;
    // quarter bit periods, rounded up so the bus never runs too fast
    localparam logic [15:0] PRESC_SLOW = 16'((CLK_HZ + 4 * SLOW_HZ - 1) / (4 * SLOW_HZ));
    localparam logic [15:0] PRESC_FAST = 16'((CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ));
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_SWITCH = 4'h8;
    localparam int CTRL_SUM_IGN = 16;
    localparam int FLAG_DONE = 0;
    localparam int FLAG_IMG = 1;
    localparam int FLAG_NACK = 2;
    localparam int FLAG_LOST = 3;
    localparam int FLAG_MISC = 4;
    localparam int FLAG_UNMAP = 5;
    localparam int STAT_BUSY = 8;
    localparam int HALT_BIT = 0;
    localparam logic [2:0] DEV_TOP = 3'h5;
    localparam logic [7:0] LOAD_MODES = 8'h0A;
    localparam logic [1:0] TYPE_SINGLE = 2'h0;
    localparam logic [1:0] TYPE_SEQ = 2'h1;
    localparam logic [1:0] TYPE_DONE = 2'h3;
    localparam logic [7:0] SUM_GOOD = 8'hFF;
    localparam logic [15:0] LAST_ADDR = 16'hFFFF;
    localparam logic [4:0] LOST_LIMIT = 5'h10;
    localparam logic [2:0] BOOT_CYCLES = 3'h4;
    localparam logic [9:0] FILT_RESET = 10'h300;
    typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} cmd_t;
endpackage

// *** core/serial_bus_byte_engine.sv ***
`timescale 1ns/1ps
module serial_bus_byte_engine
    import eeprom_loader_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_go,
    input wire cmd_t i_cmd,
    input wire logic [7:0] i_wdata,
    input wire logic i_ack,
    input wire logic [15:0] i_quarter,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_nack,
    output logic o_lost,
    output logic o_misc,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} est_t;
    typedef struct packed {
        est_t st;
        logic [1:0] q;
        logic [15:0] cnt;
        logic [3:0] nbit;
        logic [8:0] sh;
        logic rd;
        logic scl_oe;
        logic sda_oe;
        logic sda_prev;
        logic done;
        logic nack;
        logic lost;
        logic misc;
        logic [7:0] rdata;
    } eng_t;
    eng_t r;
    eng_t n;
    logic tick;
    logic lose;
    logic bad;

    always_comb begin
        n = r;
        n.done = 1'b0;
        n.sda_prev = i_sda;
        tick = 1'b0;
        lose = 1'b0;
        bad = 1'b0;
        if (r.st == E_IDLE) begin
            if (i_go) begin
                n.q = 2'h0;
                n.cnt = i_quarter;
                n.nbit = 4'h0;
                n.lost = 1'b0;
                n.misc = 1'b0;
                n.nack = 1'b0;
                n.rd = (i_cmd == CMD_READ);
                n.sh = (i_cmd == CMD_READ) ? {8'hFF, ~i_ack} : {i_wdata, 1'b1};
                case (i_cmd)
                    CMD_START: begin
                        n.st = E_START;
                        n.sda_oe = 1'b0;
                    end
                    CMD_STOP: begin
                        n.st = E_STOP;
                        n.sda_oe = 1'b1;
                    end
                    default: begin
                        n.st = E_BIT;
                        n.sda_oe = ~n.sh[8];
                    end
                endcase
            end
        end else begin
            // a slave holding the clock low stretches the first of the two high quarters
            if (r.q == 2'h1 && !i_scl) begin
                n.cnt = r.cnt;
            end else if (r.cnt != 16'h0000) begin
                n.cnt = r.cnt - 16'h0001;
            end else begin
                tick = 1'b1;
                n.cnt = i_quarter;
                n.q = r.q + 2'h1;
            end
            if (tick) begin
                case (r.q)
                    2'h0: n.scl_oe = 1'b0;
                    2'h1: begin
                        if (r.st == E_START) begin
                            lose = !i_sda;
                            n.sda_oe = 1'b1;
                        end else if (r.st == E_STOP) begin
                            n.sda_oe = 1'b0;
                        end else begin
                            n.sh = {r.sh[7:0], i_sda};
                            lose = !r.rd && r.nbit != 4'h8 && r.sh[8] && !i_sda;
                        end
                    end
                    2'h2: n.scl_oe = (r.st != E_STOP);
                    default: begin
                        if (r.st == E_BIT && r.nbit != 4'h8) begin
                            n.nbit = r.nbit + 4'h1;
                            n.sda_oe = ~r.sh[8];
                        end else begin
                            n.st = E_IDLE;
                            n.done = 1'b1;
                            n.rdata = r.sh[8:1];
                            n.nack = (r.st == E_BIT) && !r.rd && r.sh[0];
                        end
                    end
                endcase
            end
            // data must not move while the clock is high
            bad = r.st == E_BIT && r.q == 2'h2 && i_sda != r.sda_prev;
            if (lose || bad) begin
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                n.st = E_IDLE;
                n.done = 1'b1;
                n.lost = lose;
                n.misc = bad && !lose;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r <= '0;
            r.sda_prev <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_done = r.done;
    assign o_rdata = r.rdata;
    assign o_nack = r.nack;
    assign o_lost = r.lost;
    assign o_misc = r.misc;
    assign o_scl_oe = r.scl_oe;
    assign o_sda_oe = r.sda_oe;
endmodule

// *** tb/loader_sva.sv ***
`timescale 1ns/1ps
module loader_sva(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_HOT_RST,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic O_CFG_WR,
    input wire logic O_LOAD_BUSY,
    input wire logic O_RESET_HALT,
    input wire logic O_SCL_OE
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    ans_one_a: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("bus not answered");
    ans_once_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST) else $error("long answer");
    cfg_gap_a: assert property (O_CFG_WR |=> !O_CFG_WR [*8]) else $error("write too long");
    cfg_busy_a: assert property (O_CFG_WR |-> O_LOAD_BUSY) else $error("write while idle");
    abort_a: assert property (O_RESET_HALT |-> !O_CFG_WR) else $error("write after abort");
    halt_hold_a: assert property (O_RESET_HALT && !I_AVS_WRITE && !I_HOT_RST |=> O_RESET_HALT)
        else $error("halt lost");
    bus_free_a: assert property (!O_LOAD_BUSY [*2] |-> !O_SCL_OE) else $error("bus used when idle");
    hot_start_a: assert property (I_HOT_RST && !O_LOAD_BUSY |-> ##[1:16] O_LOAD_BUSY)
        else $error("no load after hot reset");
    cover property (O_CFG_WR);
    cover property ($rose(O_RESET_HALT));
    cover property ($fell(O_LOAD_BUSY));
endmodule

// *** tb/eeprom_model.sv ***
`timescale 1ns/1ps
module eeprom_model(
    input wire logic scl,
    input wire logic sda,
    output logic sda_low
);
    logic [7:0] mem [0:65535];
    logic [7:0] sh, dev;
    logic [15:0] ptr;
    logic rd, rq, on;
    int bc, st;
    initial begin
        sda_low = 0;
        on = 0;
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    always @(negedge sda) if (scl) begin
        {on, rd, rq, bc, st} = {3'h4, 32'h0, 32'h0};
    end
    always @(posedge sda) if (scl) on = 0;
    always @(posedge scl) if (on) begin
        bc++;
        if (bc < 9) sh = {sh[6:0], sda};
        else if (rd) begin
            ptr++;
            on = !sda;
        end
    end
    // bits change only while the clock is low
    always @(negedge scl) if (on) begin
        if (bc == 9) {bc, rd} = {32'h0, rq};
        if (bc == 8) begin
            sda_low = !rd;
            if (!rd) begin
                case (st)
                    0: {dev, rq} = {sh, sh[0]};
                    1: ptr[15:8] = sh;
                    2: ptr[7:0] = sh;
                endcase
                st++;
            end
        end else sda_low = rd && !mem[ptr][7 - bc];
    end
endmodule

// *** tb/smbus_eeprom_config_loader_tb.sv ***
`timescale 1ns/1ps
module smbus_eeprom_config_loader_tb;
    import eeprom_loader_pkg::*;
    logic clk = 0, nrst = 0, hot = 0, rd = 0, wr = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, rdq;
    logic [15:0] ca;
    logic [31:0] cd;
    logic [47:0] wq[$];
    logic [7:0] img[18] = '{8'h10, 8'h00, 8'h44, 8'h33, 8'h22, 8'h11, 8'h20, 8'h40, 8'h02, 8'h00,
        8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hE0, 8'hE1, 8'hE2, 8'hE3};
    logic [47:0] ew[3] = '{{16'h0040, 32'h11223344}, {16'h0080, 32'hD3D2D1D0}, {16'h0084, 32'hE3E2E1E0}};
    logic scl_oe, sda_oe, sda_low, wrq, cwr, busy, halt;
    int n_errors = 0, cmp_count = 0;
    wire logic scl = !scl_oe;
    wire logic sda = !(sda_oe || sda_low);
    // the register file has no word at 0x0084
    wire logic miss = cwr && ca == 16'h0084;
    always #10 clk = !clk;
    always @(posedge clk) if (cwr) wq.push_back({ca, cd});
    smbus_eeprom_config_loader u_smbus_eeprom_config_loader(.I_CLK(clk), .I_NRST(nrst), .I_HOT_RST(hot),
        .I_MASTER_BUS_SLOW_STRAP(1'b0), .I_SWITCH_OPERATING_STRAP(3'h1), .I_MASTER_BUS_ADDRESS_PINS(4'hA),
        .I_SCL(scl), .I_SDA(sda), .O_SCL(), .O_SCL_OE(scl_oe), .O_SDA(), .O_SDA_OE(sda_oe),
        .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF),
        .O_AVS_READDATA(rdq), .O_AVS_WAITREQUEST(wrq), .O_CFG_WR(cwr), .O_CFG_ADDR(ca), .O_CFG_DATA(cd),
        .I_CFG_MISS(miss), .O_LOAD_BUSY(busy), .O_RESET_HALT(halt));
    eeprom_model u_eeprom_model(.scl(scl), .sda(sda), .sda_low(sda_low));
    task summarize;
        $display("counts: %0d compares, %0d errors", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [47:0] g, input logic [47:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {adr, wd, wr, rd} <= {a, d, w, !w};
        do begin
            @(posedge clk);
            n++;
        end while (wrq !== 1'b0);
        rdat = rdq;
        {wr, rd} <= 2'b00;
        chk(n, 2);
        @(posedge clk);
    endtask
    // checksum is the ones-complement of the byte sum, with the bits set in bad flipped
    task put(input logic [7:0] bad);
        logic [7:0] s;
        s = 8'hC0;
        foreach (img[i]) {u_eeprom_model.mem[i], s} = {img[i], s + img[i]};
        {u_eeprom_model.mem[18], u_eeprom_model.mem[19]} = {~s ^ bad, 8'hC0};
    endtask
    task load(input logic [31:0] st, input logic h);
        int n;
        n = 0;
        wq.delete();
        hot <= h;
        @(posedge clk);
        hot <= 1'b0;
        while (busy !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        while (busy !== 1'b0 && n < 40000) begin @(posedge clk); n++; end
        bus(0, OFS_STAT, 0);
        chk(rdat, st);
        chk(wq.size(), 3);
        foreach (ew[i]) chk(wq[i], ew[i]);
    endtask
    task t_good;
        load(32'h21, 0);
        chk(u_eeprom_model.dev, 8'hB5);
        chk(halt, 0);
        $display("good image done");
    endtask
    task t_bad;
        bus(0, OFS_CTRL, 0);
        chk(rdat, {16'h0, PRESC_FAST});
        bus(1, OFS_CTRL, 32'h4);
        put(8'h01);
        load(32'h23, 1);
        chk(halt, 1);
        bus(0, 4'hC, 0);
        chk(rdat, 0);
        $display("bad sum done");
    endtask
    task t_ign;
        bus(1, OFS_SWITCH, 0);
        chk(halt, 0);
        bus(1, OFS_CTRL, 32'h0001_0004);
        load(32'h21, 1);
        chk(halt, 0);
        $display("ignored sum done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        // after the model has blanked its memory
        put(8'h00);
        nrst <= 1'b1;
        t_good;
        t_bad;
        t_ign;
        summarize;
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        summarize;
    end
endmodule
bind smbus_eeprom_config_loader loader_sva u_loader_sva(.I_CLK(I_CLK), .I_NRST(I_NRST), .I_HOT_RST(I_HOT_RST),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .O_CFG_WR(O_CFG_WR), .O_LOAD_BUSY(O_LOAD_BUSY), .O_RESET_HALT(O_RESET_HALT), .O_SCL_OE(O_SCL_OE));
